// ### verilog/field_capture_pkg.sv
// Package: register map, field layout, timing and states of field capture
package field_capture_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_SWITCH = 8'h00;
  localparam logic [7:0] ADDR_FIELD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_DATA_LO = 8'h0c;
  localparam logic [7:0] ADDR_DATA_HI = 8'h10;
  localparam logic [7:0] ADDR_CTRL = 8'h14;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int FLD_START_LSB = 0;
  localparam int FLD_START_IDX = 7;
  localparam int FLD_WIDTH_LSB = 8;
  localparam int FLD_WIDTH_IDX = 15;
  localparam int FLD_COUNT_LSB = 16;
  localparam int FLD_TYPE_LSB = 20;
  localparam int FLD_DIGIT_C = 1;
  localparam int FLD_DIGIT_D = 0;
  localparam int CTRL_TRIG_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam logic [15:0] SWITCH_RST = 16'h0000;
  localparam logic [31:0] FIELD_RST = 32'h0001_0801;

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [3:0] DIGIT_KEEP = 4'h9;
  localparam logic [3:0] DIGIT_ERR = 4'h9;
  localparam logic [3:0] MODE_PULSED = 4'h1;
  localparam logic [3:0] MODE_FAST = 4'h2;
  localparam logic [1:0] TYPE_RX_UINT = 2'h0;
  localparam logic [1:0] TYPE_RX_FIXED = 2'h1;
  localparam logic [1:0] TYPE_TX = 2'h2;
  localparam logic [1:0] TYPE_CFG = 2'h3;
  localparam logic [6:0] FIXED_WIDTH = 7'h20;
  localparam logic [3:0] TRIG_ADDR = 4'hf;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_KHZ = 250000;
  localparam int T_HIGH_MS = 50;
  localparam int T_LOW_MS = 1;
  localparam int T_BLINK_MS = 50;
  localparam int T_BOOT_MS = 6000;
  localparam int HIGH_CYC = T_HIGH_MS * CLK_KHZ;
  localparam int LOW_CYC = T_LOW_MS * CLK_KHZ;
  localparam int BLINK_CYC = T_BLINK_MS * CLK_KHZ;
  localparam int BOOT_CYC = T_BOOT_MS * CLK_KHZ;

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_IDLE,
    ST_PULSE,
    ST_WAIT_LOW,
    ST_FAST_HI,
    ST_FAST_LO
  } line_state_type;

endpackage : field_capture_pkg

// ### verilog/can_field_capture_notify.sv
// Field capture, group trigger freeze and data-ready line driver
//
// Operation
// - Switch readback returns stored digits; digit 9 marks an internal error.
// - Start pointer 1..64 selects field LSB, counted from right by default.
// - Indexed start pointer counts LSB position from the left instead.
// - Width 1..64; fixed-width data type forces its own width.
// - Indexed width marks the request for data-ready notification.
// - Each further value moves position by width: plus right, minus left.
// - Notification only for receive types, never transmit or config.
// - Interrupt stays pending until every marked new value is read.
// - Notification works only with mode digit 1 (pulsed) or 2 (fast).
// - Pulsed: idle released low; pending drives high 50 ms if line low.
// - Pulsed: after line high, wait 50 ms continuous low before driving.
// - Fast: raise at once on new data; lower once data is read or mode changes.
// - Fast: while unread, 1 ms low after every 50 ms high.
// - After power-up or restart, blink line at 50 ms for 6 s.
// - Group trigger copies latest capture to working buffer, then freezes.
// - In trigger mode, reads return frozen values from one instant.
// - Group trigger is broadcast on peripheral bus address 33 base 4.
// - Mode digit defaults to 0, notification off.
`timescale 1ns/1ps

module can_field_capture_notify
  import field_capture_pkg::*;
#(
  parameter int unsigned HIGH_CYCLES = HIGH_CYC,
  parameter int unsigned LOW_CYCLES = LOW_CYC,
  parameter int unsigned BLINK_CYCLES = BLINK_CYC,
  parameter int unsigned BOOT_CYCLES = BOOT_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [63:0] I_CAN_DATA,
  input wire logic I_CAN_VALID,
  input wire logic [3:0] I_PBUS_ADDR,
  input wire logic I_PBUS_STROBE,
  input wire logic I_DRDY_I,
  output logic O_DRDY_O,
  output logic O_DRDY_OE_N
);

  // ****************************************
  // Declarations
  // ****************************************
  logic aw_have_q, w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write, rd_take, rd_adv, restart_q;
  logic [15:0] switch_q;
  logic [31:0] field_q;
  logic trig_mode_q;
  logic [63:0] live_q, work_q;
  logic [3:0] idx_q;
  logic new_q;
  logic [3:0] pb_addr_meta_q, pb_addr_q;
  logic pb_stb_meta_q, pb_stb_q, pb_stb_old_q;
  logic drdy_meta_q, drdy_q;
  logic group_trig, work_load, notify_en, last_val;
  line_state_type state_q;
  logic [31:0] cnt_q, boot_q;
  logic [6:0] eff_width, lsb;
  logic [10:0] step;
  logic signed [11:0] pos;
  logic [63:0] mask, cur_value;
  logic [31:0] rd_word;
  logic [1:0] rd_resp;
  logic [3:0] mode;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign do_write = aw_have_q && w_have_q && !O_BVALID;

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      O_AWREADY <= 1'b1;
      O_WREADY <= 1'b1;
      O_BVALID <= 1'b0;
      O_BRESP <= RESP_OKAY;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_have_q <= 1'b1;
        awaddr_q <= I_AWADDR;
        O_AWREADY <= 1'b0;
      end
      if (I_WVALID && O_WREADY) begin
        w_have_q <= 1'b1;
        wdata_q <= I_WDATA;
        wstrb_q <= I_WSTRB;
        O_WREADY <= 1'b0;
      end
      if (do_write) begin
        O_BVALID <= 1'b1;
        case ({awaddr_q[7:2], 2'b00})
          ADDR_SWITCH, ADDR_FIELD, ADDR_CTRL: O_BRESP <= RESP_OKAY;
          default: O_BRESP <= RESP_SLVERR;
        endcase
      end
      if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY <= 1'b1;
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      switch_q <= SWITCH_RST;
      field_q <= FIELD_RST;
      trig_mode_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      if (restart_q) begin
        switch_q <= SWITCH_RST;
      end else if (do_write && {awaddr_q[7:2], 2'b00} == ADDR_SWITCH &&
                   wstrb_q[0] && wstrb_q[1]) begin
        for (int k = 0; k < 4; k++) begin
          // Keep code only meaningful for the mode and link digits
          if (wdata_q[4*k +: 4] == DIGIT_KEEP &&
              (k == FLD_DIGIT_C || k == FLD_DIGIT_D)) begin
            switch_q[4*k +: 4] <= switch_q[4*k +: 4];
          end else if (wdata_q[4*k +: 4] > 4'h9) begin
            switch_q[4*k +: 4] <= DIGIT_ERR;
          end else begin
            switch_q[4*k +: 4] <= wdata_q[4*k +: 4];
          end
        end
      end
      if (do_write && {awaddr_q[7:2], 2'b00} == ADDR_FIELD) begin
        field_q <= merge(field_q, wdata_q, wstrb_q);
      end
      if (do_write && {awaddr_q[7:2], 2'b00} == ADDR_CTRL && wstrb_q[0]) begin
        trig_mode_q <= wdata_q[CTRL_TRIG_BIT];
        restart_q <= wdata_q[CTRL_RESTART_BIT];
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign rd_take = I_ARVALID && O_ARREADY;
  assign rd_adv = rd_take && {I_ARADDR[7:2], 2'b00} == ADDR_DATA_LO;

  always_comb begin
    rd_resp = RESP_OKAY;
    case ({I_ARADDR[7:2], 2'b00})
      ADDR_SWITCH: rd_word = {16'h0000, switch_q};
      ADDR_FIELD: rd_word = field_q;
      ADDR_STATUS: rd_word = {27'h0, state_q == ST_BOOT, O_DRDY_O,
                              O_DRDY_OE_N, trig_mode_q, new_q};
      ADDR_DATA_LO: rd_word = cur_value[31:0];
      ADDR_DATA_HI: rd_word = cur_value[63:32];
      ADDR_CTRL: rd_word = {31'h0, trig_mode_q};
      default: begin
        rd_word = 32'h0000_0000;
        rd_resp = RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_ARREADY <= 1'b1;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0000_0000;
      O_RRESP <= RESP_OKAY;
    end else begin
      if (rd_take) begin
        O_ARREADY <= 1'b0;
        O_RVALID <= 1'b1;
        O_RDATA <= rd_word;
        O_RRESP <= rd_resp;
      end else if (O_RVALID && I_RREADY) begin
        O_RVALID <= 1'b0;
        O_ARREADY <= 1'b1;
      end
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      pb_addr_meta_q <= 4'h0;
      pb_addr_q <= 4'h0;
      pb_stb_meta_q <= 1'b0;
      pb_stb_q <= 1'b0;
      pb_stb_old_q <= 1'b0;
      drdy_meta_q <= 1'b0;
      drdy_q <= 1'b0;
    end else begin
      pb_addr_meta_q <= I_PBUS_ADDR;
      pb_addr_q <= pb_addr_meta_q;
      pb_stb_meta_q <= I_PBUS_STROBE;
      pb_stb_q <= pb_stb_meta_q;
      pb_stb_old_q <= pb_stb_q;
      drdy_meta_q <= I_DRDY_I;
      drdy_q <= drdy_meta_q;
    end
  end

  assign group_trig = pb_stb_q && !pb_stb_old_q &&
                      pb_addr_q == TRIG_ADDR;

  // ****************************************
  // Capture and working buffers
  // ****************************************
  // Frozen mode only reloads at a trigger, so all reads share one instant
  assign work_load = trig_mode_q ? group_trig : I_CAN_VALID;

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      live_q <= 64'h0;
      work_q <= 64'h0;
    end else begin
      if (I_CAN_VALID) begin
        live_q <= I_CAN_DATA;
      end
      if (work_load) begin
        work_q <= trig_mode_q ? live_q : I_CAN_DATA;
      end
    end
  end

  // ****************************************
  // Field extraction
  // ****************************************
  always_comb begin
    eff_width = (field_q[FLD_TYPE_LSB +: 2] == TYPE_RX_FIXED) ?
                FIXED_WIDTH : field_q[FLD_WIDTH_LSB +: 7];
    step = {7'h00, idx_q} * {4'h0, eff_width};
    if (field_q[FLD_START_IDX]) begin
      pos = $signed({5'h00, field_q[FLD_START_LSB +: 7]}) -
            $signed({1'b0, step});
      lsb = 7'(12'sd64 - pos);
    end else begin
      pos = $signed({5'h00, field_q[FLD_START_LSB +: 7]}) +
            $signed({1'b0, step});
      lsb = 7'(pos - 12'sd1);
    end
    if (eff_width >= 7'd64) begin
      mask = {64{1'b1}};
    end else begin
      mask = (64'h1 << eff_width) - 64'h1;
    end
    if (pos >= 12'sd1 && pos <= 12'sd64) begin
      cur_value = (work_q >> lsb) & mask;
    end else begin
      cur_value = 64'h0;
    end
  end

  // ****************************************
  // Notification pending and value index
  // ****************************************
  assign notify_en = field_q[FLD_WIDTH_IDX] &&
                     (field_q[FLD_TYPE_LSB +: 2] == TYPE_RX_UINT ||
                      field_q[FLD_TYPE_LSB +: 2] == TYPE_RX_FIXED);
  assign last_val = ({1'b0, idx_q} + 5'h01) >=
                    {1'b0, field_q[FLD_COUNT_LSB +: 4]};

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      idx_q <= 4'h0;
      new_q <= 1'b0;
    end else begin
      if (do_write && {awaddr_q[7:2], 2'b00} == ADDR_FIELD) begin
        idx_q <= 4'h0;
      end else if (rd_adv) begin
        idx_q <= last_val ? 4'h0 : idx_q + 4'h1;
      end
      // New data wins over the clear caused by the last read
      if (work_load && notify_en) begin
        new_q <= 1'b1;
      end else if (rd_adv && last_val) begin
        new_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Data-ready line driver
  // ****************************************
  assign mode = switch_q[4*FLD_DIGIT_C +: 4];

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_q <= ST_BOOT;
      cnt_q <= 32'h0;
      boot_q <= 32'h0;
      O_DRDY_O <= 1'b1;
      O_DRDY_OE_N <= 1'b0;
    end else if (restart_q) begin
      state_q <= ST_BOOT;
      cnt_q <= 32'h0;
      boot_q <= 32'h0;
      O_DRDY_O <= 1'b1;
      O_DRDY_OE_N <= 1'b0;
    end else begin
      case (state_q)
        ST_BOOT: begin
          cnt_q <= cnt_q + 32'h1;
          boot_q <= boot_q + 32'h1;
          if (cnt_q == BLINK_CYCLES - 1) begin
            cnt_q <= 32'h0;
            O_DRDY_O <= !O_DRDY_O;
          end
          if (boot_q == BOOT_CYCLES - 1) begin
            state_q <= ST_IDLE;
            cnt_q <= 32'h0;
            O_DRDY_O <= 1'b0;
            O_DRDY_OE_N <= 1'b1;
          end
        end
        ST_IDLE: begin
          cnt_q <= 32'h0;
          O_DRDY_O <= 1'b0;
          O_DRDY_OE_N <= 1'b1;
          if (mode == MODE_PULSED && new_q) begin
            if (!drdy_q) begin
              state_q <= ST_PULSE;
              O_DRDY_O <= 1'b1;
              O_DRDY_OE_N <= 1'b0;
            end else begin
              state_q <= ST_WAIT_LOW;
            end
          end else if (mode == MODE_FAST && new_q) begin
            state_q <= ST_FAST_HI;
            O_DRDY_O <= 1'b1;
            O_DRDY_OE_N <= 1'b0;
          end
        end
        ST_PULSE: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q == HIGH_CYCLES - 1) begin
            state_q <= ST_WAIT_LOW;
            cnt_q <= 32'h0;
            O_DRDY_O <= 1'b0;
            O_DRDY_OE_N <= 1'b1;
          end
        end
        ST_WAIT_LOW: begin
          // Any high sample restarts the quiet period
          cnt_q <= drdy_q ? 32'h0 : cnt_q + 32'h1;
          if (!drdy_q && cnt_q == HIGH_CYCLES - 1) begin
            state_q <= ST_IDLE;
            cnt_q <= 32'h0;
          end
        end
        ST_FAST_HI, ST_FAST_LO: begin
          cnt_q <= cnt_q + 32'h1;
          if (!new_q || mode != MODE_FAST) begin
            state_q <= ST_IDLE;
            cnt_q <= 32'h0;
            O_DRDY_O <= 1'b0;
            O_DRDY_OE_N <= 1'b1;
          end else if (state_q == ST_FAST_HI &&
                       cnt_q == HIGH_CYCLES - 1) begin
            state_q <= ST_FAST_LO;
            cnt_q <= 32'h0;
            O_DRDY_O <= 1'b0;
          end else if (state_q == ST_FAST_LO &&
                       cnt_q == LOW_CYCLES - 1) begin
            state_q <= ST_FAST_HI;
            cnt_q <= 32'h0;
            O_DRDY_O <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          cnt_q <= 32'h0;
          O_DRDY_O <= 1'b0;
          O_DRDY_OE_N <= 1'b1;
        end
      endcase
    end
  end

endmodule : can_field_capture_notify

// ### sim/capture_checker_properties.sv
// Checker: bus handshake and data-ready line properties
`timescale 1ns/1ps
module capture_checker
  import field_capture_pkg::*;
#(
  parameter int unsigned HIGH_CYCLES = HIGH_CYC,
  parameter int unsigned BLINK_CYCLES = BLINK_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic O_WREADY,
  input wire logic [1:0] O_BRESP,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic [1:0] O_RRESP,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic O_DRDY_O,
  input wire logic O_DRDY_OE_N
);
  // ****************
  // Helper logic
  // ****************
  // One cycle slack: the count lands an edge after the line moves
  localparam int unsigned HI_MAX = (HIGH_CYCLES > BLINK_CYCLES ?
    HIGH_CYCLES : BLINK_CYCLES) + 1;
  logic [31:0] hi_cnt_q;
  logic rd_bad;
  assign rd_bad = !({I_ARADDR[7:2], 2'b00} inside {ADDR_SWITCH,
    ADDR_FIELD, ADDR_STATUS, ADDR_DATA_LO, ADDR_DATA_HI, ADDR_CTRL});
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      hi_cnt_q <= 32'h0;
    end else if (!O_DRDY_OE_N && O_DRDY_O) begin
      hi_cnt_q <= hi_cnt_q + 32'h1;
    end else begin
      hi_cnt_q <= 32'h0;
    end
  end
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);
  // ****************
  // Properties
  // ****************
  b_hold_a: assert property (
    O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response not held");
  r_hold_a: assert property (
    O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data not held");
  r_answer_a: assert property (
    I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read answer late");
  r_unmapped_a: assert property (
    I_ARVALID && O_ARREADY && rd_bad |=>
    O_RRESP == RESP_SLVERR && O_RDATA == 32'h0)
    else $error("unmapped read answered");
  w_take_a: assert property (
    I_WVALID && O_WREADY |=> !O_WREADY)
    else $error("write data ready stayed high");
  b_answer_a: assert property (
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |=> ##1 O_BVALID)
    else $error("write response late");
  ar_block_a: assert property (
    O_RVALID |-> !O_ARREADY)
    else $error("second read taken");
  boot_drive_a: assert property (
    $rose(I_RESETN) |-> !O_DRDY_OE_N && O_DRDY_O)
    else $error("line not driven after reset");
  hi_len_a: assert property (
    hi_cnt_q <= HI_MAX)
    else $error("line held high too long");
  cover property (O_RVALID && I_RREADY && O_RRESP == RESP_SLVERR);
  cover property (O_BVALID && I_BREADY);
  cover property (hi_cnt_q == HIGH_CYCLES);
endmodule : capture_checker

bind can_field_capture_notify capture_checker #(
  .HIGH_CYCLES(HIGH_CYCLES), .BLINK_CYCLES(BLINK_CYCLES)
) i_capture_checker (
  .I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_AWVALID(I_AWVALID),
  .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
  .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
  .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
  .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID),
  .I_RREADY(I_RREADY), .O_DRDY_O(O_DRDY_O), .O_DRDY_OE_N(O_DRDY_OE_N)
);

// ### sim/host_partner.sv
// Partner: datalogger side of the shared line and peripheral bus
`timescale 1ns/1ps
module host_partner (
  input wire logic i_clk,
  input wire logic i_drive,
  input wire logic i_oe_n,
  output logic o_line,
  output logic [3:0] o_addr,
  output logic o_strobe
);
  logic other_hi = 1'b0;
  initial begin
    o_addr = 4'h0;
    o_strobe = 1'b0;
  end
  // Weak pull-down: low unless someone drives high
  assign o_line = other_hi | (!i_oe_n & i_drive);
  task automatic hold(input logic h);
    @(posedge i_clk);
    other_hi <= h;
  endtask : hold
  task automatic trig(input logic [3:0] a);
    @(posedge i_clk);
    o_addr <= a;
    repeat (3) @(posedge i_clk);
    o_strobe <= 1'b1;
    repeat (3) @(posedge i_clk);
    o_strobe <= 1'b0;
    repeat (3) @(posedge i_clk);
    // Released pins must not keep showing the old address
    o_addr <= ~a;
  endtask : trig
endmodule : host_partner

// ### sim/test_can_field_capture_notify.sv
// Testbench: registers, field capture, notification, group trigger
`timescale 1ns/1ps
module test_can_field_capture_notify
  import field_capture_pkg::*;
;
  localparam int HI = 20;
  localparam int BL = 10;
  localparam int BT = 100;
  localparam logic [15:0] SW_IN [3] = '{16'h0102, 16'h0999, 16'h00b0};
  localparam logic [15:0] SW_EXP [3] = '{16'h0102, 16'h0902, 16'h0090};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, can_valid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [63:0] can_data = 64'h0;
  wire awready, wready, bvalid, arready, rvalid, drdy_o, drdy_oe_n;
  wire line, strobe;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] paddr;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #2 clk = ~clk;

  can_field_capture_notify #(.HIGH_CYCLES(HI), .LOW_CYCLES(8),
    .BLINK_CYCLES(BL), .BOOT_CYCLES(BT)) i_dut (
    .I_CLK(clk), .I_RESETN(resetn), .I_AWADDR(awaddr),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
    .I_WSTRB(4'hf), .I_WVALID(wvalid), .O_WREADY(wready),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
    .I_RREADY(rready), .I_CAN_DATA(can_data), .I_CAN_VALID(can_valid),
    .I_PBUS_ADDR(paddr), .I_PBUS_STROBE(strobe), .I_DRDY_I(line),
    .O_DRDY_O(drdy_o), .O_DRDY_OE_N(drdy_oe_n));
  host_partner i_host (.i_clk(clk), .i_drive(drdy_o), .i_oe_n(drdy_oe_n),
    .o_line(line), .o_addr(paddr), .o_strobe(strobe));

  // ****************
  // Bus tasks and checks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  function automatic logic [63:0] fexp(input logic [63:0] v,
                                       input logic [31:0] f, input int k);
    int w, pos;
    logic [63:0] x;
    w = (f[21:20] == TYPE_RX_FIXED) ? int'(FIXED_WIDTH) : int'(f[14:8]);
    pos = f[7] ? int'(f[6:0]) - k * w : int'(f[6:0]) + k * w;
    if (pos < 1 || pos > 64) return 64'h0;
    x = v >> (f[7] ? 64 - pos : pos - 1);
    if (w < 64) x = x & ((64'h1 << w) - 64'h1);
    return x;
  endfunction : fexp
  // High half first: reading the low half moves to the next value
  task automatic getv(input logic [63:0] v, input logic [31:0] f,
                      input int k);
    logic [31:0] d;
    logic [1:0] r;
    logic [63:0] e;
    e = fexp(v, f, k); // Unit multiplier, zero offset
    rd(ADDR_DATA_HI, d, r);
    chk(d, e[63:32]);
    rd(ADDR_DATA_LO, d, r);
    chk(d, e[31:0]);
  endtask : getv
  task automatic pulse(input logic [63:0] v);
    @(posedge clk);
    can_data <= v;
    can_valid <= 1'b1;
    @(posedge clk);
    can_valid <= 1'b0;
  endtask : pulse
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      $display("[FAIL] %0t run did not finish", $time);
      report_and_stop();
    end
  end

  // ****************
  // Tests
  // ****************
  initial begin
    logic [31:0] d, f;
    logic [1:0] r;
    logic [63:0] v, va;
    int n, k, tg;
    d = $urandom(32'h6e167803);
    tg = 0;
    // Line is driven high throughout reset
    v[0] = 1'b1;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (BT + 10) begin
      @(posedge clk);
      if (!drdy_oe_n && drdy_o !== v[0]) tg++;
      v[0] = drdy_o;
    end
    chk(32'(tg), 32'(BT / BL - 1));
    rd(ADDR_STATUS, d, r);
    chk({d[4], drdy_oe_n}, 2'b01);
    rd(ADDR_SWITCH, d, r);
    chk(d, 32'h0);
    rd(ADDR_FIELD, d, r);
    chk(d, FIELD_RST);
    rd(8'h18, d, r);
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    wr(8'h18, 32'hffff_ffff, r);
    chk(r, RESP_SLVERR);
    for (n = 0; n < 3; n++) begin
      wr(ADDR_SWITCH, SW_IN[n], r);
      chk(r, RESP_OKAY);
      rd(ADDR_SWITCH, d, r);
      chk(d, SW_EXP[n]);
    end
    wr(ADDR_SWITCH, 32'h0, r);
    $display("test reset and switches done");
    for (n = 0; n < 14; n++) begin
      if (n == 0) f = 32'h0000_4001;
      else if (n == 1) f = 32'h0002_0cc0;
      else f = {10'h0, 2'($urandom_range(1)), 4'($urandom_range(3, 1)),
        1'b0, 7'($urandom_range(64, 1)), 1'($urandom),
        7'($urandom_range(64, 1))};
      v = {$urandom, $urandom};
      wr(ADDR_FIELD, f, r);
      pulse(v);
      // Count zero still yields one value
      for (k = 0; k < int'(f[19:16]) + int'(f[19:16] == 4'h0); k++)
        getv(v, f, k);
    end
    $display("test field extraction done");
    wr(ADDR_SWITCH, 32'h0020, r);
    f = 32'h0012_8801;
    wr(ADDR_FIELD, f, r);
    pulse(v);
    repeat (3) @(posedge clk);
    chk({drdy_oe_n, drdy_o}, 2'b01);
    repeat (HI) @(posedge clk);
    chk({drdy_oe_n, drdy_o}, 2'b00);
    while (!line) @(posedge clk);
    getv(v, f, 0);
    rd(ADDR_STATUS, d, r);
    chk(d[0], 1'b1);
    getv(v, f, 1);
    rd(ADDR_STATUS, d, r);
    chk({d[0], drdy_oe_n}, 2'b01);
    f = 32'h0021_8801;
    wr(ADDR_FIELD, f, r);
    pulse(v);
    rd(ADDR_STATUS, d, r);
    chk({d[0], drdy_oe_n}, 2'b01);
    wr(ADDR_SWITCH, 32'h0, r);
    f = 32'h0001_8801;
    wr(ADDR_FIELD, f, r);
    pulse(v);
    repeat (4) @(posedge clk);
    chk(drdy_oe_n, 1'b1);
    getv(v, f, 0);
    $display("test fast mode done");
    wr(ADDR_SWITCH, 32'h0010, r);
    i_host.hold(1'b1);
    pulse(v);
    repeat (HI / 2) @(posedge clk);
    chk(drdy_oe_n, 1'b1);
    i_host.hold(1'b0);
    repeat (HI / 2) @(posedge clk);
    chk(drdy_oe_n, 1'b1);
    repeat (HI) @(posedge clk);
    chk({drdy_oe_n, drdy_o}, 2'b01);
    repeat (HI) @(posedge clk);
    chk(drdy_oe_n, 1'b1);
    getv(v, f, 0);
    wr(ADDR_SWITCH, 32'h0, r);
    $display("test pulsed mode done");
    f = 32'h0001_4001;
    wr(ADDR_FIELD, f, r);
    wr(ADDR_CTRL, 32'h1, r);
    va = {$urandom, $urandom};
    v = {$urandom, $urandom};
    pulse(va);
    i_host.trig(TRIG_ADDR);
    pulse(v);
    getv(va, f, 0);
    i_host.trig(4'he);
    getv(va, f, 0);
    i_host.trig(TRIG_ADDR);
    getv(v, f, 0);
    wr(ADDR_SWITCH, 32'h0021, r);
    wr(ADDR_CTRL, 32'h2, r);
    rd(ADDR_STATUS, d, r);
    chk({d[4], d[1]}, 2'b10);
    rd(ADDR_SWITCH, d, r);
    chk(d, 32'h0);
    $display("test group trigger done");
    report_and_stop();
  end
endmodule : test_can_field_capture_notify
